// [sms_cfg.svh]
// Constants of the serial memory pin-level slave.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SMS_CFG_SVH
`define SMS_CFG_SVH

// =====================================================================
// Timing
`define SMS_SYS_CLK_HZ  125000000
`define SMS_SCK_MAX_HZ  16000000
// Least system cycles per serial clock half period that sampling needs
`define SMS_MIN_HALF_CYC 3

// =====================================================================
// Synchroniser lane positions
`define SMS_PIN_CS   0
`define SMS_PIN_SCK  1
`define SMS_PIN_SI   2
`define SMS_PIN_HOLD 3
`define SMS_PIN_WP   4
`define SMS_PIN_NUM  5

// =====================================================================
// Frame layout and reset values
`define SMS_BYTE_W     8
`define SMS_CNT_W      3
`define SMS_LAST_BIT   3'h7
`define SMS_PIN_RST    5'h1b
`define SMS_BUF_DEPTH  2

`endif

// [sms_pkg.sv]
// Types of the serial memory pin-level slave.
// Assumes sms_cfg.svh is on the include path.
`include "sms_cfg.svh"

package sms_pkg;

	// =================================================================
	// Received byte with its position in the frame
	typedef struct packed
	{
		logic                    first;
		logic [`SMS_BYTE_W-1:0] data;
	} sms_rx_t;

	// =================================================================
	// Frame state
	typedef enum logic [1:0]
	{
		SMS_IDLE   = 2'b00,
		SMS_ACTIVE = 2'b01,
		SMS_IGNORE = 2'b10
	} sms_state_t;

endpackage

// [sms_buf2.sv]
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock; read data come out of a register.
`include "sms_cfg.svh"

module sms_buf2
#(
	parameter int W     = 9,
	parameter int DEPTH = `SMS_BUF_DEPTH
)
(
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);

	// =================================================================
	// Elaboration check
	if (DEPTH != 2)
	begin : g_depth_chk
		$error("sms_buf2 serves exactly two entries");
	end

	logic [W-1:0] head_r;
	logic [W-1:0] tail_r;
	logic [1:0]   cnt_r;
	logic         push;
	logic         pop;

	assign in_ready  = (cnt_r != 2'h2);
	assign out_valid = (cnt_r != 2'h0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = head_r;

	// =================================================================
	// Occupancy
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_r <= 2'h0;
		else if (push & ~pop)
			cnt_r <= cnt_r + 2'h1;
		else if (pop & ~push)
			cnt_r <= cnt_r - 2'h1;
	end

	// =================================================================
	// Storage
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			head_r <= '0;
			tail_r <= '0;
		end
		else
		begin
			if (pop)
				head_r <= (cnt_r == 2'h2) ? tail_r : in_data;
			else if (push & (cnt_r == 2'h0))
				head_r <= in_data;
			if (push & ((cnt_r == 2'h2) | ((cnt_r == 2'h1) & ~pop)))
				tail_r <= in_data;
		end
	end

	no_overfill_a: assert property (@(posedge clk) disable iff (!rst_n)
		cnt_r <= 2'h2)
		else $error("buffer count above two");

endmodule

// [sms_spi_slave.sv]
// Pin-level serial slave of a byte-wide serial memory.
// Assumes pins arrive asynchronous to sys_clk; user logic shares sys_clk.
`include "sms_cfg.svh"

module sms_spi_slave
#(
	parameter int SYS_CLK_HZ = `SMS_SYS_CLK_HZ,
	parameter int SCK_MAX_HZ = `SMS_SCK_MAX_HZ
)
(
	input  wire logic                    sys_clk,
	input  wire logic                    rst_n,
	input  wire logic                    cs_n,
	input  wire logic                    sck,
	input  wire logic                    si,
	output logic                         so,
	output logic                         so_oe,
	input  wire logic                    hold_n,
	input  wire logic                    wp_n,
	output sms_pkg::sms_rx_t             rx_word,
	output logic                         rx_valid,
	input  wire logic                    rx_ready,
	output logic                         rx_overrun,
	input  wire logic                    op_reject,
	input  wire logic                    tx_drive,
	input  wire logic [`SMS_BYTE_W-1:0] tx_data,
	input  wire logic                    tx_valid,
	output logic                         tx_ready,
	input  wire logic                    protect_pin_arm_bit,
	output logic                         sr_wr_ok,
	output logic                         selected
);

	// =================================================================
	// Elaboration check
	if (SYS_CLK_HZ / (2 * SCK_MAX_HZ) < `SMS_MIN_HALF_CYC)
	begin : g_rate_chk
		$error("sys_clk too slow to sample the serial clock");
	end

	logic [`SMS_PIN_NUM-1:0] sync1_r;
	logic [`SMS_PIN_NUM-1:0] sync2_r;
	logic                    sck_d_r;
	logic                    cs_q_r;
	sms_pkg::sms_state_t     state_r;
	logic [`SMS_CNT_W-1:0]   bit_cnt_r;
	logic                    first_r;
	logic [`SMS_BYTE_W-1:0]  rx_sh_r;
	logic [`SMS_BYTE_W-1:0]  tx_sh_r;
	logic                    so_r;
	logic                    oe_r;
	logic                    ovr_r;
	logic                    wr_ok_r;
	logic                    msb_seen_r;
	logic                    cs_s;
	logic                    sck_s;
	logic                    si_s;
	logic                    hold_s;
	logic                    wp_s;
	logic                    run;
	logic                    rise;
	logic                    fall;
	logic                    cs_fall;
	logic                    cs_rise;
	logic                    act;
	logic                    push;
	logic                    push_rdy;
	logic                    tx_load;
	sms_pkg::sms_rx_t        push_word;

	// =================================================================
	// Pin synchronisers
	localparam logic [`SMS_PIN_NUM-1:0] PIN_RST = `SMS_PIN_RST;

	genvar gi;
	for (gi = 0; gi < `SMS_PIN_NUM; gi++)
	begin : g_sync
		always_ff @(posedge sys_clk or negedge rst_n)
		begin
			if (!rst_n)
			begin
				sync1_r[gi] <= PIN_RST[gi];
				sync2_r[gi] <= PIN_RST[gi];
			end
			else
			begin
				sync1_r[gi] <= (gi == `SMS_PIN_CS)   ? cs_n :
				               (gi == `SMS_PIN_SCK)  ? sck :
				               (gi == `SMS_PIN_SI)   ? si :
				               (gi == `SMS_PIN_HOLD) ? hold_n : wp_n;
				sync2_r[gi] <= sync1_r[gi];
			end
		end
	end

	assign cs_s   = sync2_r[`SMS_PIN_CS];
	assign sck_s  = sync2_r[`SMS_PIN_SCK];
	assign si_s   = sync2_r[`SMS_PIN_SI];
	assign hold_s = sync2_r[`SMS_PIN_HOLD];
	assign wp_s   = sync2_r[`SMS_PIN_WP];

	// =================================================================
	// Edge detection, frozen while paused
	assign run     = hold_s;
	assign act     = (state_r == sms_pkg::SMS_ACTIVE);
	assign rise    = run & act & sck_s & ~sck_d_r;
	assign fall    = run & act & ~sck_s & sck_d_r;
	assign cs_fall = run & cs_q_r & ~cs_s;
	assign cs_rise = run & ~cs_q_r & cs_s;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			sck_d_r <= 1'b0;
		else
			sck_d_r <= sck_s;
	end

	// Chip select level seen by the slave; held during a pause
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			cs_q_r <= 1'b1;
		else if (run)
			cs_q_r <= cs_s;
	end

	// =================================================================
	// Frame state
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			state_r <= sms_pkg::SMS_IDLE;
		else
		begin
			case (state_r)
				sms_pkg::SMS_IDLE:
					if (cs_fall)
						state_r <= sms_pkg::SMS_ACTIVE;
				sms_pkg::SMS_ACTIVE:
					if (cs_rise)
						state_r <= sms_pkg::SMS_IDLE;
					else if (op_reject & run)
						state_r <= sms_pkg::SMS_IGNORE;
				sms_pkg::SMS_IGNORE:
					if (cs_rise)
						state_r <= sms_pkg::SMS_IDLE;
				default:
					state_r <= sms_pkg::SMS_IDLE;
			endcase
		end
	end

	// =================================================================
	// Receive path
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bit_cnt_r <= '0;
			first_r   <= 1'b0;
			rx_sh_r   <= '0;
		end
		else if (cs_fall)
		begin
			bit_cnt_r <= '0;
			first_r   <= 1'b1;
		end
		else if (rise)
		begin
			rx_sh_r   <= {rx_sh_r[`SMS_BYTE_W-2:0], si_s};
			bit_cnt_r <= bit_cnt_r + 3'h1;
			if (bit_cnt_r == `SMS_LAST_BIT)
				first_r <= 1'b0;
		end
	end

	assign push       = rise & (bit_cnt_r == `SMS_LAST_BIT);
	assign push_word  = '{first: first_r, data: {rx_sh_r[`SMS_BYTE_W-2:0], si_s}};

	sms_buf2
	#(
		.W     ($bits(sms_pkg::sms_rx_t)),
		.DEPTH (`SMS_BUF_DEPTH)
	)
	u_rx_buf
	(
		.clk       (sys_clk),
		.rst_n     (rst_n),
		.in_valid  (push),
		.in_ready  (push_rdy),
		.in_data   (push_word),
		.out_valid (rx_valid),
		.out_ready (rx_ready),
		.out_data  (rx_word)
	);

	// Lost byte; a new push wins over the clear at selection
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			ovr_r <= 1'b0;
		else if (push & ~push_rdy)
			ovr_r <= 1'b1;
		else if (cs_fall)
			ovr_r <= 1'b0;
	end

	assign rx_overrun = ovr_r;

	// First bit of each byte, kept apart from the shifter
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			msb_seen_r <= 1'b0;
		else if (rise & (bit_cnt_r == '0))
			msb_seen_r <= si_s;
	end

	// =================================================================
	// Transmit path
	assign tx_load  = fall & (bit_cnt_r == '0) & tx_drive & tx_valid;
	assign tx_ready = tx_load;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_sh_r <= '0;
			so_r    <= 1'b0;
			oe_r    <= 1'b0;
		end
		else if (!act)
			oe_r <= 1'b0;
		else if (fall)
		begin
			if (tx_load)
			begin
				so_r    <= tx_data[`SMS_BYTE_W-1];
				tx_sh_r <= {tx_data[`SMS_BYTE_W-2:0], 1'b0};
				oe_r    <= 1'b1;
			end
			else if (bit_cnt_r == '0)
				oe_r <= 1'b0;
			else
			begin
				so_r    <= tx_sh_r[`SMS_BYTE_W-1];
				tx_sh_r <= {tx_sh_r[`SMS_BYTE_W-2:0], 1'b0};
			end
		end
	end

	assign so    = so_r;
	assign so_oe = oe_r & hold_s & act;

	// =================================================================
	// Status register write guard
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			wr_ok_r <= 1'b0;
		else
			wr_ok_r <= ~(protect_pin_arm_bit & ~wp_s);
	end

	assign sr_wr_ok = wr_ok_r;
	assign selected = ~cs_q_r;

	// =================================================================
	// Checks
	idle_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cs_q_r |-> !so_oe)
		else $error("output driven while deselected");

	pause_release_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!hold_s |-> !so_oe)
		else $error("output driven while paused");

	pause_freeze_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!hold_s ##1 !hold_s |-> $stable(bit_cnt_r) && $stable(cs_q_r))
		else $error("state moved while paused");

	rise_count_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rise |=> bit_cnt_r == $past(bit_cnt_r) + 3'h1)
		else $error("bit count missed a rising edge");

	no_edge_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!act |=> $stable(bit_cnt_r) || $past(cs_fall))
		else $error("bit count moved while not selected");

	select_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cs_fall |=> bit_cnt_r == '0 && first_r ##0 (!push) [*2])
		else $error("frame did not restart at selection");

	msb_first_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		push |-> push_word.data[7] == msb_seen_r && push_word.data[0] == si_s)
		else $error("received byte not in order");

	reject_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_r == sms_pkg::SMS_IGNORE |-> !so_oe && !push)
		else $error("activity after a rejected opcode");

	guard_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		protect_pin_arm_bit && !wp_s |=> !sr_wr_ok)
		else $error("status write allowed while protected");

	out_on_fall_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$changed(so_r) |-> $past(fall))
		else $error("output changed off a falling edge");

	byte_cover_c: cover property (@(posedge sys_clk) disable iff (!rst_n) push && first_r);
	read_cover_c: cover property (@(posedge sys_clk) disable iff (!rst_n) tx_load);
	pause_cover_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
		act && bit_cnt_r != '0 && !hold_s);
	reject_cover_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
		state_r == sms_pkg::SMS_IGNORE);

endmodule

// [sms_mst_model.sv]
// Serial bus master model that drives the slave's pins other than wp_n.
// Assumes the bench sets cpol and calls one task at a time.
module sms_mst_model
(
	output logic      cs_n,
	output logic      sck,
	output logic      si,
	output logic      hold_n,
	input  wire logic so,
	input  wire logic so_oe
);
	timeunit 1ns;
	timeprecision 100ps;

	localparam real HALF = 62.5;
	logic cpol  = 1'b0;
	logic b     = 1'b0;
	logic oe_p  = 1'b0;
	logic oe_s  = 1'b0;

	initial
	begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
		hold_n = 1'b1;
	end

	// =================================================================
	// Frame tasks
	task automatic start();
		sck = cpol;
		#HALF cs_n = 1'b0;
		#HALF;
	endtask

	task automatic xfer(input logic [7:0] tx, input int hold_at, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			sck = 1'b0;
			si = tx[i];
			if (i == hold_at)
			begin
				#HALF hold_n = 1'b0;
				repeat (3)
				begin
					#HALF sck = 1'b1;
					si = ~si;
					if (so_oe === 1'b1)
						oe_p = 1'b1;
					#HALF sck = 1'b0;
				end
				#HALF hold_n = 1'b1;
				si = tx[i];
			end
			#HALF sck = 1'b1;
			if (so_oe === 1'b1)
				oe_s = 1'b1;
			// Released line shows the inverse of the last bit
			b = so_oe ? so : ~b;
			rx[i] = b;
			#HALF;
		end
	endtask

	task automatic stop();
		#HALF cs_n = 1'b1;
		si = ~si;
		#HALF sck = cpol;
		#HALF;
	endtask
endmodule

// [serial_memory_spi_slave_pins_tb.sv]
// Self-checking bench of the serial memory pin-level slave.
// Assumes sms_mst_model drives the pins other than wp_n; wp_n and the user side are driven here.
`define SMS_CHK(a, e) \
	begin \
		n_tests++; \
		if ((a) !== (e)) \
		begin \
			fails++; \
			$display("wrong value at %0t: got %h expected %h", $time, a, e); \
		end \
	end

module serial_memory_spi_slave_pins_tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic             sys_clk   = 1'b0;
	logic             rst_n     = 1'b0;
	logic             wp_n      = 1'b1;
	logic             rx_ready  = 1'b1;
	logic             op_reject = 1'b0;
	logic             tx_drive  = 1'b0;
	logic [7:0]       tx_data   = 8'h00;
	logic             tx_valid  = 1'b0;
	logic             arm       = 1'b0;
	logic             cs_n, sck, si, so, so_oe, hold_n;
	logic             rx_valid, rx_overrun, tx_ready, sr_wr_ok, selected;
	logic [7:0]       d, r;
	sms_pkg::sms_rx_t rx_word, e;
	sms_pkg::sms_rx_t exp_q[$];
	int               fails     = 0;
	int               n_tests   = 0;
	int               n_rdy     = 0;
	int               seed      = 32'h09649d24;

	sms_mst_model m (.cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .so(so), .so_oe(so_oe));

	sms_spi_slave uut (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si),
		.so(so), .so_oe(so_oe), .hold_n(hold_n), .wp_n(wp_n), .rx_word(rx_word),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_overrun(rx_overrun),
		.op_reject(op_reject), .tx_drive(tx_drive), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .protect_pin_arm_bit(arm), .sr_wr_ok(sr_wr_ok),
		.selected(selected));

	initial
		forever #4 sys_clk = ~sys_clk;

	// =================================================================
	// Receive monitor
	always @(posedge sys_clk)
		if (rx_valid === 1'b1 && rx_ready === 1'b1)
		begin
			`SMS_CHK(exp_q.size() != 0, 1'b1)
			if (exp_q.size() != 0)
			begin
				e = exp_q.pop_front();
				`SMS_CHK(rx_word, e)
			end
		end

	// Count read bytes taken from the user side
	always @(posedge sys_clk)
		if (tx_ready === 1'b1)
			n_rdy++;

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Byte out on si; noted as expected when the slave must keep it
	task automatic wr(input logic first, input logic keep, input int hold_at);
		d = 8'($random(seed));
		if (keep)
			exp_q.push_back({first, d});
		m.xfer(d, hold_at, r);
	endtask

	// Drive user inputs at a falling edge, then step off the clock grid
	task automatic user(input logic drv, input logic rej, input logic rdy);
		@(negedge sys_clk);
		tx_data <= 8'($random(seed));
		tx_drive <= drv;
		tx_valid <= drv;
		op_reject <= rej;
		rx_ready <= rdy;
		#0.2;
	endtask

	initial
	begin
		#400000;
		fails++;
		end_of_test();
	end

	// =================================================================
	// Main sequence
	initial
	begin
		repeat (16) @(posedge sys_clk);
		@(negedge sys_clk) rst_n <= 1'b1;
		repeat (4) @(negedge sys_clk);
		`SMS_CHK({so_oe, rx_valid, selected, rx_overrun}, 4'h0)
		for (int k = 0; k < 4; k++)
		begin
			@(negedge sys_clk);
			arm <= k[1];
			wp_n <= k[0];
			repeat (4) @(negedge sys_clk);
			`SMS_CHK(sr_wr_ok, ~(k[1] & ~k[0]))
		end
		for (int md = 0; md < 2; md++)
		begin
			m.cpol = md[0];
			// Receiver stalls: two bytes held, third dropped
			user(1'b0, 1'b0, 1'b0);
			m.start();
			`SMS_CHK(selected, 1'b1)
			wr(1'b1, 1'b1, -1);
			wr(1'b0, 1'b1, 3);
			wr(1'b0, 1'b0, -1);
			`SMS_CHK({rx_valid, rx_overrun}, 2'h3)
			user(1'b0, 1'b0, 1'b1);
			m.stop();
			`SMS_CHK(selected, 1'b0)
			// Read byte with a pause in mid-byte
			m.start();
			`SMS_CHK(rx_overrun, 1'b0)
			wr(1'b1, 1'b1, -1);
			user(1'b1, 1'b0, 1'b1);
			m.oe_p = 1'b0;
			wr(1'b0, 1'b1, 4);
			`SMS_CHK(r, tx_data)
			`SMS_CHK(m.oe_p, 1'b0)
			`SMS_CHK(n_rdy, md + 1)
			user(1'b0, 1'b0, 1'b1);
			m.stop();
			`SMS_CHK(so_oe, 1'b0)
			// Rejected opcode: rest of frame ignored
			m.start();
			wr(1'b1, 1'b1, -1);
			user(1'b1, 1'b1, 1'b1);
			m.oe_s = 1'b0;
			wr(1'b0, 1'b0, -1);
			wr(1'b0, 1'b0, 2);
			`SMS_CHK(m.oe_s, 1'b0)
			`SMS_CHK(n_rdy, md + 1)
			user(1'b0, 1'b0, 1'b1);
			m.stop();
		end
		repeat (20) @(negedge sys_clk);
		`SMS_CHK(exp_q.size(), 0)
		end_of_test();
	end
endmodule
